// ==== hdl/dshr_regs.sv ====
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
module dshr_regs
  import dshr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] in_present,
  input wire logic [3:0] in1_priority,
  input wire logic [3:0] in2_priority,
  input wire logic [15:0] phase_average,
  input wire logic [31:0] integral_frequency,
  input wire logic [31:0] long_average_frequency,
  input wire logic loop_frequency_offset_at_limit,
  input wire logic [1:0] holdover_mode_select,
  output logic [31:0] manual_holdover_frequency,
  output logic manual_holdover_active
);

  // --------------------------------------------------------------------------
  // input synchronisers (status comes from the loop domain)
  // --------------------------------------------------------------------------
  logic [1:0] pres_s1_q, pres_q;
  logic lim_s1_q, lim_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pres_s1_q <= 2'h0;
      pres_q <= 2'h0;
      lim_s1_q <= 1'b0;
      lim_q <= 1'b0;
    end
    else
    begin
      pres_s1_q <= in_present;
      pres_q <= pres_s1_q;
      lim_s1_q <= loop_frequency_offset_at_limit;
      lim_q <= lim_s1_q;
    end
  end

  // --------------------------------------------------------------------------
  // bus handshake
  // --------------------------------------------------------------------------
  logic [7:0] awaddr_q, araddr_q;
  logic aw_have_q, w_have_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic [7:0] ctrl_q;
  logic [7:0] hof_q [4];
  logic do_write, do_read;
  logic wr_hit;

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign wr_hit = (awaddr_q >= DSHR_HOLD_B0_ADDR && awaddr_q <= DSHR_HOLD_B3_ADDR)
    || awaddr_q == DSHR_CTRL_ADDR;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= DSHR_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? DSHR_RESP_OKAY : DSHR_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // writable registers
  // --------------------------------------------------------------------------
  // holdover bytes are staged; the live word changes only when the top byte
  // lands, so the loop never sees a half-written offset
  logic [31:0] hof_live_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= DSHR_CTRL_RESET;
      hof_live_q <= {4{DSHR_BYTE_RESET}};
      for (int i = 0; i < 4; i++)
        hof_q[i] <= DSHR_BYTE_RESET;
    end
    else if (do_write && wstrb0_q)
    begin
      if (awaddr_q == DSHR_CTRL_ADDR)
        ctrl_q <= wdata_q;
      for (int i = 0; i < 4; i++)
        if (awaddr_q == DSHR_HOLD_B0_ADDR + 8'(i))
          hof_q[i] <= wdata_q;
      if (awaddr_q == DSHR_HOLD_B3_ADDR)
        hof_live_q <= {wdata_q, hof_q[2], hof_q[1], hof_q[0]};
    end
  end

  assign manual_holdover_frequency = hof_live_q;
  assign manual_holdover_active = holdover_mode_select == DSHR_HOLD_MODE_MANUAL;

  // --------------------------------------------------------------------------
  // reference priority status
  // --------------------------------------------------------------------------
  logic [1:0] valid_in;
  logic [3:0] best_d, second_d;
  logic [3:0] best_valid_input_q, second_best_valid_input_q, selected_input_q;
  logic sel_ok;

  // an input is valid if present, enabled by software and given a priority
  assign valid_in[0] = pres_q[0] && ctrl_q[DSHR_CTRL_VALID_LSB] && in1_priority != 4'h0;
  assign valid_in[1] = pres_q[1] && ctrl_q[DSHR_CTRL_VALID_LSB + 1]
    && in2_priority != 4'h0;

  always_comb
  begin
    best_d = DSHR_REF_NONE;
    second_d = DSHR_REF_NONE;
    if (valid_in[0] && valid_in[1])
    begin
      // ties go to input one
      best_d = (in2_priority < in1_priority) ? DSHR_REF_IN2 : DSHR_REF_IN1;
      second_d = (in2_priority < in1_priority) ? DSHR_REF_IN1 : DSHR_REF_IN2;
    end
    else if (valid_in[0])
      best_d = DSHR_REF_IN1;
    else if (valid_in[1])
      best_d = DSHR_REF_IN2;
  end

  assign sel_ok = (selected_input_q == DSHR_REF_IN1 && valid_in[0])
    || (selected_input_q == DSHR_REF_IN2 && valid_in[1]);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      best_valid_input_q <= DSHR_REF_NONE;
      second_best_valid_input_q <= DSHR_REF_NONE;
      selected_input_q <= DSHR_REF_NONE;
    end
    else
    begin
      best_valid_input_q <= best_d;
      second_best_valid_input_q <= second_d;
      // nonrevertive: a still-valid selection is kept
      if (ctrl_q[DSHR_CTRL_RETURN_BIT] || !sel_ok)
        selected_input_q <= best_d;
    end
  end

  // --------------------------------------------------------------------------
  // frequency word source and freeze
  // --------------------------------------------------------------------------
  logic [31:0] loop_frequency_offset_word_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      loop_frequency_offset_word_q <= {4{DSHR_BYTE_RESET}};
    else if (ctrl_q[DSHR_CTRL_AVGSEL_BIT])
      loop_frequency_offset_word_q <= long_average_frequency;
    else if (!(ctrl_q[DSHR_CTRL_FREEZE_BIT] && lim_q))
      loop_frequency_offset_word_q <= integral_frequency;
  end

  // --------------------------------------------------------------------------
  // read path with low-byte snapshots
  // --------------------------------------------------------------------------
  logic [15:0] phase_snap_q;
  logic [31:0] loop_frequency_offset_snap_q;
  logic [7:0] rd_addr;
  logic [7:0] rd_byte;
  logic rd_hit;

  assign rd_addr = s_axi_araddr[9:2];

  always_comb
  begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    unique case (rd_addr)
      DSHR_HOLD_B0_ADDR: rd_byte = hof_q[0];
      DSHR_HOLD_B1_ADDR: rd_byte = hof_q[1];
      DSHR_HOLD_B2_ADDR: rd_byte = hof_q[2];
      DSHR_HOLD_B3_ADDR: rd_byte = hof_q[3];
      DSHR_PRIO_ADDR: rd_byte = {best_valid_input_q, selected_input_q};
      DSHR_SECOND_ADDR: rd_byte = {4'h0, second_best_valid_input_q};
      DSHR_PHASE_B0_ADDR: rd_byte = phase_average[7:0];
      DSHR_PHASE_B1_ADDR: rd_byte = phase_snap_q[15:8];
      DSHR_LOOP_FREQUENCY_OFFSET_B0_ADDR: rd_byte = loop_frequency_offset_word_q[7:0];
      DSHR_LOOP_FREQUENCY_OFFSET_B1_ADDR: rd_byte = loop_frequency_offset_snap_q[15:8];
      DSHR_LOOP_FREQUENCY_OFFSET_B2_ADDR: rd_byte = loop_frequency_offset_snap_q[23:16];
      DSHR_LOOP_FREQUENCY_OFFSET_B3_ADDR: rd_byte = loop_frequency_offset_snap_q[31:24];
      DSHR_CTRL_ADDR: rd_byte = ctrl_q;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase_snap_q <= 16'h0000;
      loop_frequency_offset_snap_q <= 32'h0000_0000;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= DSHR_RESP_OKAY;
    end
    else
    begin
      if (do_read)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_hit ? DSHR_RESP_OKAY : DSHR_RESP_SLVERR;
        if (rd_addr == DSHR_PHASE_B0_ADDR)
          phase_snap_q <= phase_average;
        if (rd_addr == DSHR_LOOP_FREQUENCY_OFFSET_B0_ADDR)
          loop_frequency_offset_snap_q <= loop_frequency_offset_word_q;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_loop_frequency_offset_low_read;
    do_read && rd_addr == DSHR_LOOP_FREQUENCY_OFFSET_B0_ADDR;
  endsequence

  // the top byte write is the single commit point of the holdover word
  sequence s_hold_top_write;
    do_write && wstrb0_q && awaddr_q == DSHR_HOLD_B3_ADDR;
  endsequence

  a_loop_frequency_offset_snapshot_taken: assert property (
    s_loop_frequency_offset_low_read |=> loop_frequency_offset_snap_q == $past(loop_frequency_offset_word_q))
    else $error("frequency snapshot not taken on low byte read");
  a_phase_snapshot_taken: assert property (
    do_read && rd_addr == DSHR_PHASE_B0_ADDR |=> phase_snap_q == $past(phase_average))
    else $error("phase snapshot not taken on low byte read");
  a_loop_frequency_offset_freeze_holds: assert property (
    !ctrl_q[DSHR_CTRL_AVGSEL_BIT] && ctrl_q[DSHR_CTRL_FREEZE_BIT] && lim_q
    |=> $stable(loop_frequency_offset_word_q))
    else $error("frequency word moved while frozen");
  a_avg_source_used: assert property (
    ctrl_q[DSHR_CTRL_AVGSEL_BIT] |=> loop_frequency_offset_word_q == $past(long_average_frequency))
    else $error("long average not selected");
  a_integral_source: assert property (
    !ctrl_q[DSHR_CTRL_AVGSEL_BIT] && !ctrl_q[DSHR_CTRL_FREEZE_BIT]
    |=> loop_frequency_offset_word_q == $past(integral_frequency))
    else $error("integral path not selected");
  a_no_invalid_best: assert property (
    !valid_in[0] |=> best_valid_input_q != DSHR_REF_IN1 || $past(valid_in[0]))
    else $error("invalid input one shown as best");
  a_second_needs_two: assert property (
    !(valid_in[0] && valid_in[1]) |=> second_best_valid_input_q == DSHR_REF_NONE)
    else $error("second reference shown with fewer than two valid");
  a_nonrevert_keeps: assert property (
    !ctrl_q[DSHR_CTRL_RETURN_BIT] && sel_ok |=> $stable(selected_input_q))
    else $error("selection changed in nonrevertive mode");
  a_hof_coherent: assert property (
    !(do_write && wstrb0_q && awaddr_q == DSHR_HOLD_B3_ADDR) |=> $stable(hof_live_q))
    else $error("holdover word changed without top byte write");
  a_hof_commit: assert property (
    s_hold_top_write |=> hof_live_q
      == {$past(wdata_q), $past(hof_q[2]), $past(hof_q[1]), $past(hof_q[0])})
    else $error("holdover word bytes committed out of place");
  a_return_to_best_enable_follows: assert property (
    ctrl_q[DSHR_CTRL_RETURN_BIT] |=> selected_input_q == $past(best_d))
    else $error("revertive selection did not follow best input");
  a_sel_never_invalid: assert property (
    !valid_in[0] |=> selected_input_q != DSHR_REF_IN1)
    else $error("invalid input one shown as selected");
  a_in2_never_invalid: assert property (
    !valid_in[1] |=> best_valid_input_q != DSHR_REF_IN2
      && second_best_valid_input_q != DSHR_REF_IN2 && selected_input_q != DSHR_REF_IN2)
    else $error("invalid input two shown in a status field");
  a_best_codes: assert property (best_valid_input_q <= DSHR_REF_IN2)
    else $error("unused best reference code");

endmodule

// ==== hdl/dshr_pkg.sv ====
package dshr_pkg;

  // --------------------------------------------------------------------------
  // register byte addresses
  // --------------------------------------------------------------------------
  localparam logic [7:0] DSHR_HOLD_B0_ADDR = 8'h92;
  localparam logic [7:0] DSHR_HOLD_B1_ADDR = 8'h93;
  localparam logic [7:0] DSHR_HOLD_B2_ADDR = 8'h94;
  localparam logic [7:0] DSHR_HOLD_B3_ADDR = 8'h95;
  localparam logic [7:0] DSHR_PRIO_ADDR = 8'h96;
  localparam logic [7:0] DSHR_SECOND_ADDR = 8'h97;
  localparam logic [7:0] DSHR_PHASE_B0_ADDR = 8'h98;
  localparam logic [7:0] DSHR_PHASE_B1_ADDR = 8'h99;
  localparam logic [7:0] DSHR_LOOP_FREQUENCY_OFFSET_B0_ADDR = 8'h9a;
  localparam logic [7:0] DSHR_LOOP_FREQUENCY_OFFSET_B1_ADDR = 8'h9b;
  localparam logic [7:0] DSHR_LOOP_FREQUENCY_OFFSET_B2_ADDR = 8'h9c;
  localparam logic [7:0] DSHR_LOOP_FREQUENCY_OFFSET_B3_ADDR = 8'h9d;
  localparam logic [7:0] DSHR_CTRL_ADDR = 8'ha4;

  // --------------------------------------------------------------------------
  // control register fields and reset values
  // --------------------------------------------------------------------------
  localparam int DSHR_CTRL_AVGSEL_BIT = 0;
  localparam int DSHR_CTRL_FREEZE_BIT = 1;
  localparam int DSHR_CTRL_RETURN_BIT = 2;
  localparam int DSHR_CTRL_VALID_LSB = 4;
  localparam logic [7:0] DSHR_CTRL_RESET = 8'h00;
  localparam logic [7:0] DSHR_BYTE_RESET = 8'h00;
  localparam logic [1:0] DSHR_HOLD_MODE_MANUAL = 2'h1;

  // --------------------------------------------------------------------------
  // reference codes
  // --------------------------------------------------------------------------
  localparam logic [3:0] DSHR_REF_NONE = 4'h0;
  localparam logic [3:0] DSHR_REF_IN1 = 4'h1;
  localparam logic [3:0] DSHR_REF_IN2 = 4'h2;

  localparam logic [1:0] DSHR_RESP_OKAY = 2'h0;
  localparam logic [1:0] DSHR_RESP_SLVERR = 2'h2;

  // software wait after a change of the averaging select
  localparam int DSHR_AVG_WAIT_US = 50;
  localparam int DSHR_CLK_MHZ = 200;
  localparam int DSHR_AVG_WAIT_CYC = DSHR_AVG_WAIT_US * DSHR_CLK_MHZ;

endpackage

// ==== verification/dshr_tb.sv ====
`timescale 1ns/10ps
module tb
  import dshr_pkg::*;
();
  typedef struct packed {logic [7:0] ctl; logic [1:0] pres; logic [3:0] p1; logic [3:0] p2;
    logic [7:0] prio; logic [7:0] sec;} dshr_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, hact;
  logic [3:0] wstrb = 4'h0, p1 = 4'h0, p2 = 4'h0;
  logic [1:0] bresp, rresp, rs, pres = 2'h0, hmode = 2'h0;
  logic [15:0] phase = 16'h0;
  logic [31:0] integ = 32'h0, lavg = 32'h0, hfreq;
  logic at_lim = 1'b0;
  int err_count = 0;
  int n_compared = 0;
  // revertive rows; row order also walks the selection through every code
  dshr_row_t rows [8] = '{
    '{8'h34, 2'h3, 4'h1, 4'h2, 8'h11, 8'h02}, '{8'h34, 2'h3, 4'h3, 4'h2, 8'h22, 8'h01},
    '{8'h34, 2'h3, 4'h2, 4'h2, 8'h11, 8'h02}, '{8'h14, 2'h3, 4'h3, 4'h2, 8'h11, 8'h00},
    '{8'h24, 2'h3, 4'h1, 4'h2, 8'h22, 8'h00}, '{8'h34, 2'h1, 4'h1, 4'h1, 8'h11, 8'h00},
    '{8'h34, 2'h3, 4'h0, 4'h5, 8'h22, 8'h00}, '{8'h04, 2'h3, 4'h1, 4'h2, 8'h00, 8'h00}};

  always #2.5 aclk = ~aclk;

  dshr_regs dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .in_present(pres), .in1_priority(p1), .in2_priority(p2),
    .phase_average(phase), .integral_frequency(integ), .long_average_frequency(lavg),
    .loop_frequency_offset_at_limit(at_lim), .holdover_mode_select(hmode), .manual_holdover_frequency(hfreq),
    .manual_holdover_active(hact));

  // ---------------------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("compares %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic hang;
    err_count++;
    $display("Error at %0t ns: bus answer timed out", $time);
    wrap_up();
  endtask

  task automatic hold(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // registers sit at four times their index, one byte per word
  task automatic wchk(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s,
    input logic [1:0] r);
    int k;
    @(posedge aclk);
    awaddr <= {22'h0, idx, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (k == 50)
      hang();
    chk({32'h0, rs}, {32'h0, r});
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] r);
    int k;
    @(posedge aclk);
    araddr <= {22'h0, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (k == 50)
      hang();
    chk({rs, rd}, {r, 24'h0, e});
  endtask

  task automatic rdw(input logic [7:0] idx, input int n, input logic [31:0] w);
    for (int j = 0; j < n; j++)
      rchk(8'(idx + j), w[8*j+:8], DSHR_RESP_OKAY);
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    hold(6);
    aresetn <= 1'b1;
    for (int a = 0; a < 12; a++)
      rchk(8'(DSHR_HOLD_B0_ADDR + a), 8'h00, DSHR_RESP_OKAY);
    rchk(DSHR_CTRL_ADDR, DSHR_CTRL_RESET, DSHR_RESP_OKAY);
    foreach (rows[i])
    begin
      wchk(DSHR_CTRL_ADDR, rows[i].ctl, 4'h1, DSHR_RESP_OKAY);
      pres <= rows[i].pres;
      p1 <= rows[i].p1;
      p2 <= rows[i].p2;
      hold(6);
      rchk(DSHR_PRIO_ADDR, rows[i].prio, DSHR_RESP_OKAY);
      rchk(DSHR_SECOND_ADDR, rows[i].sec, DSHR_RESP_OKAY);
    end
    // a better input must not steal the selection while revertive is off
    wchk(DSHR_CTRL_ADDR, 8'h30, 4'h1, DSHR_RESP_OKAY);
    pres <= 2'h1;
    p1 <= 4'h3;
    p2 <= 4'h1;
    hold(6);
    rchk(DSHR_PRIO_ADDR, 8'h11, DSHR_RESP_OKAY);
    pres <= 2'h3;
    hold(6);
    rchk(DSHR_PRIO_ADDR, 8'h21, DSHR_RESP_OKAY);
    rchk(DSHR_SECOND_ADDR, 8'h01, DSHR_RESP_OKAY);
    wchk(DSHR_CTRL_ADDR, 8'h34, 4'h1, DSHR_RESP_OKAY);
    hold(3);
    rchk(DSHR_PRIO_ADDR, 8'h22, DSHR_RESP_OKAY);
    // live sources move between byte reads to prove the snapshot
    phase <= 16'h8123;
    hold(2);
    rchk(DSHR_PHASE_B0_ADDR, 8'h23, DSHR_RESP_OKAY);
    phase <= 16'h0000;
    hold(2);
    rchk(DSHR_PHASE_B1_ADDR, 8'h81, DSHR_RESP_OKAY);
    integ <= 32'h89abcdef;
    lavg <= 32'h12345678;
    hold(2);
    rchk(DSHR_LOOP_FREQUENCY_OFFSET_B0_ADDR, 8'hef, DSHR_RESP_OKAY);
    integ <= 32'h0;
    rdw(DSHR_LOOP_FREQUENCY_OFFSET_B1_ADDR, 3, 32'h0089abcd);
    wchk(DSHR_CTRL_ADDR, 8'h35, 4'h1, DSHR_RESP_OKAY);
    hold(DSHR_AVG_WAIT_CYC);
    rdw(DSHR_LOOP_FREQUENCY_OFFSET_B0_ADDR, 4, 32'h12345678);
    wchk(DSHR_CTRL_ADDR, 8'h36, 4'h1, DSHR_RESP_OKAY);
    hold(DSHR_AVG_WAIT_CYC);
    integ <= 32'h0a0b0c0d;
    hold(2);
    at_lim <= 1'b1;
    hold(6);
    integ <= 32'h55667788;
    hold(3);
    rdw(DSHR_LOOP_FREQUENCY_OFFSET_B0_ADDR, 4, 32'h0a0b0c0d);
    at_lim <= 1'b0;
    hold(6);
    rdw(DSHR_LOOP_FREQUENCY_OFFSET_B0_ADDR, 4, 32'h55667788);
    hmode <= DSHR_HOLD_MODE_MANUAL;
    rdw(DSHR_HOLD_B0_ADDR, 4, 32'h0);
    wchk(DSHR_HOLD_B0_ADDR, 8'h44, 4'h1, DSHR_RESP_OKAY);
    wchk(DSHR_HOLD_B1_ADDR, 8'h33, 4'h1, DSHR_RESP_OKAY);
    wchk(DSHR_HOLD_B2_ADDR, 8'h22, 4'h1, DSHR_RESP_OKAY);
    chk({2'h0, hfreq}, 34'h0);
    wchk(DSHR_HOLD_B3_ADDR, 8'h11, 4'h1, DSHR_RESP_OKAY);
    chk({1'b0, hact, hfreq}, {2'b01, 32'h11223344});
    rchk(DSHR_HOLD_B2_ADDR, 8'h22, DSHR_RESP_OKAY);
    wchk(DSHR_HOLD_B0_ADDR, 8'h99, 4'h0, DSHR_RESP_OKAY);
    rchk(DSHR_HOLD_B0_ADDR, 8'h44, DSHR_RESP_OKAY);
    hmode <= 2'h2;
    hold(1);
    chk({33'h0, hact}, 34'h0);
    // refused accesses: unmapped read, write to a status byte
    rchk(8'h00, 8'h00, DSHR_RESP_SLVERR);
    wchk(DSHR_PRIO_ADDR, 8'h5a, 4'h1, DSHR_RESP_SLVERR);
    rchk(DSHR_PRIO_ADDR, 8'h22, DSHR_RESP_OKAY);
    aresetn <= 1'b0;
    hold(2);
    aresetn <= 1'b1;
    chk({2'h0, hfreq}, 34'h0);
    rchk(DSHR_CTRL_ADDR, DSHR_CTRL_RESET, DSHR_RESP_OKAY);
    rchk(DSHR_PRIO_ADDR, 8'h00, DSHR_RESP_OKAY);
    wrap_up();
  end
endmodule
